// file: wwdt_defines.svh
/*
  Constants of the windowed watchdog: register offsets, field positions,
  reset values and timing figures.
  Assumes a byte address bus of WWDT_ADDR_W bits and 32-bit data.
*/
`ifndef WWDT_DEFINES_SVH
`define WWDT_DEFINES_SVH

// Register offsets
`define WWDT_ADDR_W       8
`define WWDT_OFS_MODE     8'h00
`define WWDT_OFS_CTRL     8'h04
`define WWDT_OFS_VALUE    8'h08
`define WWDT_OFS_ISTS     8'h0c
`define WWDT_OFS_IMASK    8'h10

// Mode register fields
`define WWDT_F_RELOAD     11:0
`define WWDT_B_FIEN       12
`define WWDT_B_RSTEN      13
`define WWDT_B_RPROC      14
`define WWDT_B_DIS        15
`define WWDT_F_WINDOW     27:16
`define WWDT_B_DBGHLT     28
`define WWDT_B_IDLEHLT    29

// Reserved bits 31:30 of the mode register read as zero
`define WWDT_MODE_MASK    32'h3fff_ffff
`define WWDT_MODE_RST     32'h0fff_2fff

// Control register
`define WWDT_B_RESTART    0

// Event bits of status and mask
`define WWDT_EV_W         2
`define WWDT_EV_UFL       0
`define WWDT_EV_ERR       1

// Timing
`define WWDT_CNT_W        12
`define WWDT_CLK_HZ       25000000
`define WWDT_SLOW_HZ      32768
`define WWDT_SLOW_DIV     (`WWDT_CLK_HZ / `WWDT_SLOW_HZ)
`define WWDT_GUARD_TICKS  3

`endif

// file: wwdt_pkg.sv
/*
  Types of the windowed watchdog.
  Assumes wwdt_defines.svh is on the include path.
*/
`include "wwdt_defines.svh"

package wwdt_pkg;

  typedef logic [`WWDT_CNT_W-1:0]  wwdt_cnt_t;
  typedef logic [`WWDT_ADDR_W-1:0] wwdt_addr_t;
  typedef logic [`WWDT_EV_W-1:0]   wwdt_ev_t;

  typedef struct packed {
    logic [31:0] mode;
    logic        mode_done;
    wwdt_cnt_t   cnt;
    wwdt_ev_t    ists;
    wwdt_ev_t    imask;
    logic [31:0] rdata;
    logic        wdt_rst;
    logic        proc_rst;
    logic        periph_rst;
  } wwdt_state_s;

endpackage

// file: wwdt_slow_div.sv
/*
  Slow-clock divider: one-cycle tick every DIV reference cycles.
  Assumes run is a level from the core; while low the phase restarts.
*/
`timescale 1ns/1ps
`include "wwdt_defines.svh"

module wwdt_slow_div #(
  parameter int DIV = `WWDT_SLOW_DIV
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // Core side
  wwdt_tick_if.div  tk
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] div_r;

  // Idle divider keeps a disabled watchdog quiet
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_r <= '0;
    end else if (!tk.run || div_r == LAST) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + W'(1);
    end
  end

  assign tk.tick = tk.run && (div_r == LAST);
endmodule

// file: wwdt_tb_top.sv
/*
  Self-checking bench for the windowed watchdog top, one task a scenario.
  Assumes wwdt_defines.svh on the include path; slow tick shortened to 4.
*/
`timescale 1ns/1ps
`include "wwdt_defines.svh"

module wwdt_tb_top;
  import wwdt_pkg::*;
  localparam int DIV = 4;
  logic        i_ref_clk;
  logic        i_rst_n;
  wwdt_addr_t  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        i_dbg_state;
  logic        i_idle_state;
  wwdt_cnt_t   o_count;
  logic        o_irq;
  logic        o_wdt_rst;
  logic        o_proc_rst;
  logic        o_periph_rst;
  int          fail_count = 0;
  int          checks_done = 0;
  int          pulses = 0;
  logic [31:0] got;
  wwdt_cnt_t   c0;

  wwdt_top #(.SLOW_DIV(DIV)) u_wwdt_top (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_dbg_state(i_dbg_state), .i_idle_state(i_idle_state),
    .o_count(o_count), .o_irq(o_irq), .o_wdt_rst(o_wdt_rst),
    .o_proc_rst(o_proc_rst), .o_periph_rst(o_periph_rst));

  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  // Pulses are one cycle long, so a level check could miss them
  always @(posedge i_ref_clk) if (o_wdt_rst === 1'b1) pulses++;

  ////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task boot;
    @(posedge i_ref_clk);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    #1 pulses = 0;
  endtask
  task wr(input wwdt_addr_t a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task rd(input wwdt_addr_t a);
    @(posedge i_ref_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 got = o_rdata;
  endtask
  // Ticks seen over 5 slow periods under the given debug and idle levels
  task hold(input logic d, input logic i, input wwdt_cnt_t drop);
    @(posedge i_ref_clk);
    i_dbg_state <= d; i_idle_state <= i;
    idle(1);
    c0 = o_count;
    idle(5 * DIV);
    chk(o_count, c0 - drop);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_reset_vals;
    boot;
    chk(o_count, 12'hfff);
    rd(`WWDT_OFS_MODE); chk(got, `WWDT_MODE_RST);
    hold(1'b1, 1'b1, 12'h005);
    hold(1'b0, 1'b0, 12'h005);
    wr(`WWDT_OFS_IMASK, 32'h0000_0003);
    rd(`WWDT_OFS_IMASK); chk(got, 32'h0000_0003);
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14); chk(got, 32'h0);
    rd(`WWDT_OFS_CTRL); chk(got, 32'h0);
  endtask
  task t_underflow;
    int n;
    boot;
    wr(`WWDT_OFS_MODE, 32'h0fff_3005); chk(o_count, 12'h005);
    wr(`WWDT_OFS_MODE, 32'h0);
    rd(`WWDT_OFS_MODE); chk(got, 32'h0fff_3005);
    wr(`WWDT_OFS_IMASK, 32'h0000_0003);
    c0 = o_count;
    idle(2 * DIV); chk(o_count, c0 - 12'h002);
    n = 0;
    while (o_wdt_rst !== 1'b1 && n < 8 * DIV) begin
      idle(1);
      n++;
    end
    chk(o_wdt_rst, 1'b1);
    chk(o_periph_rst, 1'b1);
    chk(o_count, 12'h005);
    idle(1); chk(o_irq, 1'b1);
    rd(`WWDT_OFS_ISTS); chk(got, 32'h1);
    wr(`WWDT_OFS_ISTS, 32'h1); chk(o_irq, 1'b0);
  endtask
  task t_early;
    boot;
    wr(`WWDT_OFS_MODE, 32'h0010_6100);
    wr(`WWDT_OFS_IMASK, 32'h0000_0003);
    wr(`WWDT_OFS_CTRL, 32'h1); chk(o_wdt_rst, 1'b1);
    chk(o_proc_rst, 1'b1);
    chk(o_periph_rst, 1'b0);
    chk(o_count < 12'h100, 1'b1);
    idle(1); chk(o_irq, 1'b0);
    rd(`WWDT_OFS_ISTS); chk(got, 32'h0);
  endtask
  task t_window;
    int n;
    boot;
    wr(`WWDT_OFS_MODE, 32'h0008_300a);
    n = 0;
    while (o_count > 12'h008 && n < 4 * DIV) begin
      idle(1);
      n++;
    end
    pulses = 0;
    wr(`WWDT_OFS_CTRL, 32'h1); chk(o_count, 12'h00a);
    idle(1); chk(pulses, 0);
    idle(3 * DIV);
    rd(`WWDT_OFS_ISTS); chk(got, 32'h0);
  endtask
  task t_disable;
    boot;
    wr(`WWDT_OFS_MODE, 32'h0fff_b005);
    c0 = o_count;
    pulses = 0;
    idle(10 * DIV); chk(o_count, c0);
    wr(`WWDT_OFS_CTRL, 32'h1); chk(o_count, c0);
    rd(`WWDT_OFS_VALUE); chk(got, 32'h5);
    chk(pulses, 0);
  endtask
  task t_halt;
    boot;
    wr(`WWDT_OFS_MODE, 32'h3010_00ff);
    hold(1'b1, 1'b0, 12'h000);
    hold(1'b0, 1'b1, 12'h000);
    hold(1'b0, 1'b0, 12'h005);
    wr(`WWDT_OFS_CTRL, 32'h1);
    idle(1); chk(pulses, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Whole run is well under a thousand cycles; this only cuts a hang
  initial begin
    #(40 * 4000);
    fail_count++;
    summarize;
  end

  initial begin
    i_rst_n = 1'b0; i_addr = '0; i_wdata = '0; i_wr = 1'b0; i_rd = 1'b0;
    i_dbg_state = 1'b0; i_idle_state = 1'b0;
    t_reset_vals;
    t_underflow;
    t_early;
    t_window;
    t_disable;
    t_halt;
    summarize;
  end
endmodule

// file: wwdt_tick_if.sv
/*
  Carrier between the watchdog core and its slow-clock divider.
  Assumes both ends share the single reference clock.
*/
`timescale 1ns/1ps

interface wwdt_tick_if;
  logic run;
  logic tick;

  modport div  (input run, output tick);
  modport core (output run, input tick);
endinterface

// file: wwdt_top.sv
/*
  Windowed watchdog: 12-bit down counter on a slow tick, restart window,
  fault interrupt and reset requests, simple register port.
  Assumes one 25 MHz clock, synchronous debug and idle levels, and a
  register master that never issues read and write together.
*/
// How it works
// - Every restart loads the programmed reload value into the counter.
// - Fault raises the interrupt only when fault interrupt enable is one.
// - Fault requests a watchdog reset only when fault reset enable is one.
// - Processor-only select limits the reset to the processor; else all.
// - Restart command works only while counter is at or below window.
// - Restart command above the window is an error fault, no restart.
// - Debug halt select freezes the counter while processor is in debug.
// - Idle halt select freezes the counter while the system is idle.
// - Timer disable set to one stops the watchdog entirely.
`timescale 1ns/1ps
`include "wwdt_defines.svh"

module wwdt_top #(
  parameter int SLOW_DIV = `WWDT_SLOW_DIV
) (
  // Clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst_n,
  // Register port
  input  wire wwdt_pkg::wwdt_addr_t i_addr,
  input  wire logic [31:0]        i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic [31:0]             o_rdata,
  // System state
  input  wire logic               i_dbg_state,
  input  wire logic               i_idle_state,
  // Results
  output wwdt_pkg::wwdt_cnt_t     o_count,
  output logic                    o_irq,
  output logic                    o_wdt_rst,
  output logic                    o_proc_rst,
  output logic                    o_periph_rst
);
  import wwdt_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic in_window(input wwdt_cnt_t cnt,
                                     input logic [31:0] mode);
    in_window = cnt <= mode[`WWDT_F_WINDOW];
  endfunction

  wwdt_state_s st_r;
  wwdt_state_s st_nxt;
  wwdt_tick_if tk ();

  logic wr_mode;
  logic wr_ctrl;
  logic restart_cmd;
  logic halted;
  logic running;
  logic ufl_ev;
  logic err_ev;
  logic fault;

  //////////////////////////////////////////////////////////////////////////
  // Slow tick

  wwdt_slow_div #(
    .DIV (SLOW_DIV)
  ) u_div (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .tk        (tk.div)
  );

  // A disabled watchdog also parks the divider phase
  assign tk.run = !st_r.mode[`WWDT_B_DIS];

  //////////////////////////////////////////////////////////////////////////
  // Event decode

  assign wr_mode     = i_wr && (i_addr == `WWDT_OFS_MODE);
  assign wr_ctrl     = i_wr && (i_addr == `WWDT_OFS_CTRL);
  assign restart_cmd = wr_ctrl && i_wdata[`WWDT_B_RESTART]
                       && !st_r.mode[`WWDT_B_DIS];

  assign halted = (st_r.mode[`WWDT_B_DBGHLT] && i_dbg_state)
               || (st_r.mode[`WWDT_B_IDLEHLT] && i_idle_state);
  assign running = !st_r.mode[`WWDT_B_DIS] && !halted;

  // Underflow when a tick finds the counter already at zero
  assign ufl_ev = running && tk.tick
                  && (st_r.cnt == '0);
  assign err_ev = restart_cmd
                  && !in_window(st_r.cnt, st_r.mode);
  assign fault  = ufl_ev || err_ev;

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt = st_r;
    st_nxt.wdt_rst    = 1'b0;
    st_nxt.proc_rst   = 1'b0;
    st_nxt.periph_rst = 1'b0;

    // Mode register takes one write only; a late write cannot disarm it
    if (wr_mode && !st_r.mode_done) begin
      st_nxt.mode      = i_wdata & `WWDT_MODE_MASK;
      st_nxt.mode_done = 1'b1;
      st_nxt.cnt       = i_wdata[`WWDT_F_RELOAD];
    end else if (restart_cmd && in_window(st_r.cnt, st_r.mode)) begin
      st_nxt.cnt = st_r.mode[`WWDT_F_RELOAD];
    end else if (ufl_ev) begin
      st_nxt.cnt = st_r.mode[`WWDT_F_RELOAD];
    end else if (running && tk.tick) begin
      st_nxt.cnt = st_r.cnt - `WWDT_CNT_W'(1);
    end

    // Faults pulse the reset requests
    if (fault && st_r.mode[`WWDT_B_RSTEN]) begin
      st_nxt.wdt_rst    = 1'b1;
      st_nxt.proc_rst   = 1'b1;
      st_nxt.periph_rst = !st_r.mode[`WWDT_B_RPROC];
    end

    // Write one to clear; a same-cycle event still wins
    if (i_wr && (i_addr == `WWDT_OFS_ISTS)) begin
      st_nxt.ists = st_r.ists & ~i_wdata[`WWDT_EV_W-1:0];
    end
    if (st_r.mode[`WWDT_B_FIEN]) begin
      if (ufl_ev) begin
        st_nxt.ists[`WWDT_EV_UFL] = 1'b1;
      end
      if (err_ev) begin
        st_nxt.ists[`WWDT_EV_ERR] = 1'b1;
      end
    end
    if (i_wr && (i_addr == `WWDT_OFS_IMASK)) begin
      st_nxt.imask = i_wdata[`WWDT_EV_W-1:0];
    end

    // Read data stands only in the cycle after the strobe
    st_nxt.rdata = '0;
    if (i_rd) begin
      if (i_addr == `WWDT_OFS_MODE) begin
        st_nxt.rdata = st_r.mode;
      end else if (i_addr == `WWDT_OFS_VALUE) begin
        st_nxt.rdata = {{(32-`WWDT_CNT_W){1'b0}}, st_r.cnt};
      end else if (i_addr == `WWDT_OFS_ISTS) begin
        st_nxt.rdata = {{(32-`WWDT_EV_W){1'b0}}, st_r.ists};
      end else if (i_addr == `WWDT_OFS_IMASK) begin
        st_nxt.rdata = {{(32-`WWDT_EV_W){1'b0}}, st_r.imask};
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r            <= '0;
      st_r.mode       <= `WWDT_MODE_RST;
      st_r.cnt        <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_rdata      = st_r.rdata;
  assign o_count      = st_r.cnt;
  assign o_irq        = |(st_r.ists & st_r.imask);
  assign o_wdt_rst    = st_r.wdt_rst;
  assign o_proc_rst   = st_r.proc_rst;
  assign o_periph_rst = st_r.periph_rst;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Ticks seen since the last good restart, saturating
  logic [1:0] since_rst_r;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      since_rst_r <= 2'h3;
    end else if (restart_cmd && !err_ev) begin
      since_rst_r <= 2'h0;
    end else if (tk.tick && since_rst_r != 2'h3) begin
      since_rst_r <= since_rst_r + 2'h1;
    end
  end

  property p_reload_on_restart;
    (restart_cmd && in_window(st_r.cnt, st_r.mode) && !wr_mode)
      |=> (st_r.cnt == $past(st_r.mode[`WWDT_F_RELOAD]));
  endproperty
  reload_on_restart_a: assert property (p_reload_on_restart)
    else $error("counter not reloaded by restart");

  fault_irq_set_a: assert property (
    (fault && st_r.mode[`WWDT_B_FIEN] && !wr_mode)
      |=> (st_r.ists != '0) ##0 (o_irq == |(st_r.ists & st_r.imask)))
    else $error("fault did not set interrupt status");

  fault_irq_quiet_a: assert property (
    (fault && !st_r.mode[`WWDT_B_FIEN] && !i_wr && st_r.ists == '0)
      |=> (st_r.ists == '0))
    else $error("interrupt status set while disabled");

  reset_gated_a: assert property (
    !(fault && st_r.mode[`WWDT_B_RSTEN])
      |=> !o_wdt_rst && !o_proc_rst && !o_periph_rst)
    else $error("reset request without enabled fault");

  reset_scope_a: assert property (
    (fault && st_r.mode[`WWDT_B_RSTEN])
      |=> o_proc_rst && (o_periph_rst == !$past(st_r.mode[`WWDT_B_RPROC]))
          ##1 (!o_proc_rst || $past(fault && st_r.mode[`WWDT_B_RSTEN])))
    else $error("wrong reset scope or length");

  window_restart_a: assert property (
    (restart_cmd && in_window(st_r.cnt, st_r.mode))
      |=> !o_wdt_rst || $past(ufl_ev))
    else $error("restart inside window raised a fault");

  early_restart_a: assert property (
    (err_ev && st_r.mode[`WWDT_B_RSTEN] && !wr_mode)
      |=> o_wdt_rst && (st_r.cnt != $past(st_r.mode[`WWDT_F_RELOAD])
                        || $past(st_r.cnt) == $past(st_r.mode[`WWDT_F_RELOAD])
                        || $past(ufl_ev)))
    else $error("early restart not treated as an error");

  halt_freeze_a: assert property (
    (halted && !i_wr) |=> $stable(st_r.cnt))
    else $error("counter moved while halted");

  disabled_quiet_a: assert property (
    (st_r.mode[`WWDT_B_DIS] && !wr_mode)
      |=> $stable(st_r.cnt) && !o_wdt_rst)
    else $error("disabled watchdog still active");

  write_once_a: assert property (
    (wr_mode && st_r.mode_done) |=> $stable(st_r.mode))
    else $error("mode register accepted a second write");

  underflow_a: assert property (
    (running && tk.tick && st_r.cnt == '0 && !i_wr)
      |=> st_r.cnt == $past(st_r.mode[`WWDT_F_RELOAD]))
    else $error("underflow did not reload counter");

  mode_reload_a: assert property (
    (wr_mode && !st_r.mode_done)
      |=> (st_r.cnt == $past(i_wdata[`WWDT_F_RELOAD])))
    else $error("first mode write did not load the counter");

  mode_masked_a: assert property (
    (wr_mode && !st_r.mode_done)
      |=> st_r.mode_done
          && (st_r.mode == ($past(i_wdata) & `WWDT_MODE_MASK)))
    else $error("first mode write not taken");

  mode_read_a: assert property (
    (i_rd && i_addr == `WWDT_OFS_MODE) |=> (o_rdata == $past(st_r.mode)))
    else $error("mode register did not read back");

  count_read_a: assert property (
    (i_rd && i_addr == `WWDT_OFS_VALUE)
      |=> (o_rdata == 32'($past(st_r.cnt))))
    else $error("counter value did not read back");

  rdata_idle_a: assert property (
    !i_rd |=> (o_rdata == '0))
    else $error("read data stood without a read");

  count_step_a: assert property (
    (running && tk.tick && st_r.cnt != '0 && !i_wr)
      |=> (st_r.cnt == $past(st_r.cnt) - `WWDT_CNT_W'(1)))
    else $error("counter did not drop by one on a tick");

  count_idle_a: assert property (
    (!tk.tick && !i_wr) |=> $stable(st_r.cnt))
    else $error("counter moved without tick or write");

  tick_gap_a: assert property (
    (SLOW_DIV > 1 && tk.tick) |=> !tk.tick)
    else $error("slow tick longer than one cycle");

  disabled_tick_a: assert property (
    st_r.mode[`WWDT_B_DIS] |-> !tk.tick)
    else $error("divider ticked while disabled");

  err_no_reload_a: assert property (
    (err_ev && !tk.tick) |=> $stable(st_r.cnt))
    else $error("early restart changed the counter");

  ufl_reset_a: assert property (
    (ufl_ev && st_r.mode[`WWDT_B_RSTEN]) |=> o_wdt_rst)
    else $error("underflow raised no reset request");

  pulse_pair_a: assert property (
    o_wdt_rst == o_proc_rst)
    else $error("processor reset apart from watchdog reset");

  periph_scope_a: assert property (
    o_periph_rst |-> o_proc_rst)
    else $error("peripheral reset without processor reset");

  ufl_status_a: assert property (
    (ufl_ev && st_r.mode[`WWDT_B_FIEN]) |=> st_r.ists[`WWDT_EV_UFL])
    else $error("underflow status not set");

  err_status_a: assert property (
    (err_ev && st_r.mode[`WWDT_B_FIEN]) |=> st_r.ists[`WWDT_EV_ERR])
    else $error("error status not set");

  status_sticky_a: assert property (
    !(i_wr && i_addr == `WWDT_OFS_ISTS)
      |=> ((st_r.ists & $past(st_r.ists)) == $past(st_r.ists)))
    else $error("status bit dropped without a clear");

  status_clear_a: assert property (
    (i_wr && i_addr == `WWDT_OFS_ISTS && !fault)
      |=> ((st_r.ists & $past(i_wdata[`WWDT_EV_W-1:0])) == '0))
    else $error("status bit survived a clear");

  mask_write_a: assert property (
    (i_wr && i_addr == `WWDT_OFS_IMASK)
      |=> (st_r.imask == $past(i_wdata[`WWDT_EV_W-1:0])))
    else $error("mask register not written");

  halt_quiet_a: assert property (
    (halted && !i_wr) |=> !o_wdt_rst)
    else $error("fault raised while halted");

  ctrl_zero_a: assert property (
    (wr_ctrl && !i_wdata[`WWDT_B_RESTART] && !tk.tick)
      |=> $stable(st_r.cnt) && !o_wdt_rst)
    else $error("control write without restart acted");

  early_change_c: cover property (
    wr_mode && since_rst_r < 2'(`WWDT_GUARD_TICKS));
  underflow_c: cover property (ufl_ev ##1 o_wdt_rst);
  early_err_c: cover property (err_ev ##1 o_irq);
  good_restart_c: cover property (restart_cmd && !err_ev);
  disabled_restart_c: cover property (wr_ctrl && st_r.mode[`WWDT_B_DIS]);
endmodule
